// ---- core/cbsel_arbiter.sv ----
// Combinational scan of transmit buffers for the highest-priority candidate
`timescale 1ns/1ps
`include "cbsel_regs.svh"
module cbsel_arbiter #(
   parameter int NBUF = 16,
   parameter int IW   = 4
) (
   input  wire logic [NBUF*4-1:0]  codes,
   input  wire logic [NBUF*11-1:0] ids,
   input  wire logic [IW-1:0]      lastIdx,
   output logic                    found,
   output logic [IW-1:0]           winner
);
   // Lowest identifier wins; ties go to the lower index
   always_comb begin
      logic [10:0] best;
      best   = 11'h7FF;
      found  = 1'b0;
      winner = '0;
      for (int i = 0; i < NBUF; i++) begin
         if (i <= int'(lastIdx) && codes[i*4 +: 4] == `CBSEL_CODE_TX_DATA &&
             (!found || ids[i*11 +: 11] < best)) begin
            found  = 1'b1;
            best   = ids[i*11 +: 11];
            winner = IW'(i);
         end
      end
   end
endmodule : cbsel_arbiter

// ---- core/cbsel_core.sv ----
// Message-buffer management, transmit selection and module disable handshake
`timescale 1ns/1ps
`include "cbsel_regs.svh"
module cbsel_core #(
   parameter int NBUF = 16,
   parameter int IW   = 4
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [15:0]       module_config_reg,
   input  wire logic [IW-1:0]     last_buffer_index,
   input  wire logic              module_disable_request,
   input  wire logic              freezeReq,
   input  wire logic              csWrite,
   input  wire logic [IW-1:0]     csIdx,
   input  wire logic [3:0]        csCode,
   input  wire logic [10:0]       csId,
   input  wire logic              frameStart,
   input  wire logic              frameEnd,
   input  wire logic              intermissionBit3,
   input  wire logic              dominantSample,
   input  wire logic              rxRemote,
   input  wire logic [10:0]       rxId,
   input  wire logic              rxOwnFrame,
   input  wire logic              txSent,
   output logic                   txValid,
   output logic [10:0]            txId,
   output logic [IW-1:0]          txIdx,
   output logic [14:0]            txCrc,
   output logic                   busIdle,
   output logic                   clockStopReq,
   output logic                   low_power_ack,
   output logic                   freeze_ack,
   output logic                   rxStored,
   output logic [IW-1:0]          rxIdx
);
   // ==========================================================
   // Buffer storage
   logic [3:0]  code_q [NBUF];
   logic [10:0] id_q   [NBUF];
   logic [NBUF*4-1:0]  codeFlat;
   logic [NBUF*11-1:0] idFlat;
   genvar g;
   generate
      for (g = 0; g < NBUF; g++) begin : gFlat
         assign codeFlat[g*4 +: 4]   = code_q[g];
         assign idFlat[g*11 +: 11]   = id_q[g];
      end
   endgenerate

   // ==========================================================
   // Phase tracking and mode
   cbsel_pkg::cbsel_phase_t phase_q;
   cbsel_pkg::cbsel_mode_t  mode_q;
   logic arbFound;
   logic [IW-1:0] arbWin;
   logic prevValid_q;
   logic [10:0] prevId_q;
   logic cancel_q;

   cbsel_arbiter #(.NBUF(NBUF), .IW(IW)) i_cbsel_arbiter (
      .codes   (codeFlat),
      .ids     (idFlat),
      .lastIdx (last_buffer_index),
      .found   (arbFound),
      .winner  (arbWin)
   );

   // Stall cause: last buffer is remote-answer and request does not match it
   wire lastIsAnswer = code_q[last_buffer_index] == `CBSEL_CODE_TX_RANSWER;
   wire remoteMiss   = rxRemote && frameEnd && lastIsAnswer &&
                       rxId != id_q[last_buffer_index];
   wire answerHit    = rxRemote && frameEnd && rxId == id_q[last_buffer_index];
   wire inInter      = phase_q == cbsel_pkg::CBSEL_INTERMISSION;
   wire earlySof     = inInter && intermissionBit3 && dominantSample;
   wire latchWin     = inInter && !earlySof;
   wire rearm        = csWrite || frameStart;
   wire selfBlock    = module_config_reg[`CBSEL_MCR_SELF_RECEIVE_DISABLE_BIT] && rxOwnFrame;
   wire multiMatch   = module_config_reg[`CBSEL_MCR_MULTI_BUFFER_MATCH_ENABLE_BIT];

   // Mixed identifier on early start: top 8 bits from previous candidate
   wire [10:0] mixedId = {prevId_q[10 -: `CBSEL_MIXED_ID_BITS],
                          id_q[arbWin][10-`CBSEL_MIXED_ID_BITS:0]};
   wire [10:0] sendId  = earlySof && prevValid_q ? mixedId : id_q[arbWin];

   // CRC-15 over the identifier actually transmitted
   function automatic logic [14:0] crc15(input logic [10:0] d);
      logic [14:0] c;
      c = 15'h0000;
      for (int i = 10; i >= 0; i--) begin
         c = (d[i] ^ c[14]) ? ({c[13:0], 1'b0} ^ 15'h4599) : {c[13:0], 1'b0};
      end
      return c;
   endfunction : crc15

   // Receive target: first matching empty buffer, or when not queuing the first matching buffer that is empty or full
   logic rxHit;
   logic [IW-1:0] rxSel;
   always_comb begin
      rxHit = 1'b0;
      rxSel = '0;
      for (int i = 0; i < NBUF; i++) begin
         if (!rxHit && i <= int'(last_buffer_index) && id_q[i] == rxId &&
             (code_q[i] == `CBSEL_CODE_RX_EMPTY ||
              (!multiMatch && code_q[i] == `CBSEL_CODE_RX_FULL))) begin
            rxHit = 1'b1;
            rxSel = IW'(i);
         end
      end
   end

   // Bus phase
   always_ff @(posedge ref_clk) begin
      if (rst) phase_q <= cbsel_pkg::CBSEL_IDLE;
      else if (frameStart || earlySof) phase_q <= cbsel_pkg::CBSEL_FRAME;
      else if (frameEnd) phase_q <= cbsel_pkg::CBSEL_INTERMISSION;
      else if (inInter && intermissionBit3) phase_q <= cbsel_pkg::CBSEL_IDLE;
   end

   // Buffer writes from software, receive stores and transmit completion
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < NBUF; i++) begin
            code_q[i] <= `CBSEL_CODE_INACTIVE;
            id_q[i]   <= 11'h000;
         end
      end else begin
         if (frameEnd && !rxRemote && rxHit && !selfBlock)
            code_q[rxSel] <= `CBSEL_CODE_RX_FULL;
         if (txSent && txValid) code_q[txIdx] <= `CBSEL_CODE_INACTIVE;
         if (csWrite) begin
            code_q[csIdx] <= csCode;
            id_q[csIdx]   <= csId;
         end
      end
   end

   // Candidate cancel flag, cleared by a rewrite or new frame
   always_ff @(posedge ref_clk) begin
      if (rst) cancel_q <= 1'b0;
      else if (remoteMiss && !answerHit) cancel_q <= 1'b1;
      else if (rearm) cancel_q <= 1'b0;
   end

   // Candidate latch in run mode at intermission, early start, buffer write or frame start
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txValid     <= 1'b0;
         txId        <= 11'h000;
         txIdx       <= '0;
         txCrc       <= 15'h0000;
         prevValid_q <= 1'b0;
         prevId_q    <= 11'h000;
      end else if (mode_q == cbsel_pkg::CBSEL_RUN && (latchWin || earlySof || rearm)) begin
         // A rewrite or new frame lifts a pending cancel at once, even outside intermission
         txValid <= arbFound && !(cancel_q && !rearm) && !remoteMiss;
         txId    <= sendId;
         txIdx   <= arbWin;
         txCrc   <= crc15(sendId);
         if (arbFound) begin
            prevValid_q <= 1'b1;
            prevId_q    <= id_q[arbWin];
         end
      end else if (txSent || mode_q != cbsel_pkg::CBSEL_RUN) begin
         txValid <= 1'b0;
      end
   end

   // Idle indication and receive status
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busIdle  <= 1'b1;
         rxStored <= 1'b0;
         rxIdx    <= '0;
      end else begin
         busIdle  <= phase_q == cbsel_pkg::CBSEL_IDLE && !frameStart;
         rxStored <= frameEnd && !rxRemote && rxHit && !selfBlock;
         rxIdx    <= rxSel;
      end
   end

   // Module mode and disable handshake
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_q        <= cbsel_pkg::CBSEL_RUN;
         clockStopReq  <= 1'b0;
         low_power_ack <= 1'b0;
         freeze_ack    <= 1'b0;
      end else begin
         clockStopReq <= module_disable_request;
         if (module_disable_request) begin
            mode_q        <= cbsel_pkg::CBSEL_DISABLED;
            low_power_ack <= 1'b1;
            freeze_ack    <= 1'b0;
         end else if (freezeReq) begin
            mode_q        <= cbsel_pkg::CBSEL_FROZEN;
            low_power_ack <= 1'b0;
            freeze_ack    <= 1'b1;
         end else begin
            mode_q        <= cbsel_pkg::CBSEL_RUN;
            low_power_ack <= 1'b0;
            freeze_ack    <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Assertions
   property p_disable_ack;
      @(posedge ref_clk) disable iff (rst)
      module_disable_request |=> clockStopReq && low_power_ack && !freeze_ack;
   endproperty
   a_disable_ack: assert property (p_disable_ack) else $error("disable handshake wrong");
   property p_stop_follows;
      @(posedge ref_clk) disable iff (rst)
      !module_disable_request |=> !clockStopReq;
   endproperty
   a_stop_follows: assert property (p_stop_follows) else $error("stop request stuck");
   property p_cancel;
      @(posedge ref_clk) disable iff (rst)
      remoteMiss && !answerHit && !rearm |=> cancel_q;
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel not raised");
   property p_rearm;
      @(posedge ref_clk) disable iff (rst)
      rearm && !remoteMiss |=> !cancel_q;
   endproperty
   a_rearm: assert property (p_rearm) else $error("stall not cleared");
   property p_self;
      @(posedge ref_clk) disable iff (rst)
      selfBlock |=> !rxStored;
   endproperty
   a_self: assert property (p_self) else $error("own frame stored");
   property p_crc;
      @(posedge ref_clk) disable iff (rst)
      $changed(txId) |-> txCrc == crc15(txId);
   endproperty
   a_crc: assert property (p_crc) else $error("crc mismatch");
   property p_mixed;
      @(posedge ref_clk) disable iff (rst)
      earlySof && prevValid_q && mode_q == cbsel_pkg::CBSEL_RUN |=> txId[10:3] == $past(prevId_q[10:3]);
   endproperty
   a_mixed: assert property (p_mixed) else $error("early start id wrong");
   property p_idle;
      @(posedge ref_clk) disable iff (rst)
      frameStart |=> !busIdle;
   endproperty
   a_idle: assert property (p_idle) else $error("idle during frame");
   c_tx: cover property (@(posedge ref_clk) disable iff (rst) txValid && txSent);
   c_cancel: cover property (@(posedge ref_clk) disable iff (rst) remoteMiss);
   c_early: cover property (@(posedge ref_clk) disable iff (rst) earlySof);
endmodule : cbsel_core

// ---- core/cbsel_pkg.sv ----
// Types for the buffer-manager transmit selection block
package cbsel_pkg;
   typedef enum logic [1:0] {CBSEL_IDLE, CBSEL_FRAME, CBSEL_INTERMISSION} cbsel_phase_t;
   typedef enum logic [1:0] {CBSEL_RUN, CBSEL_FROZEN, CBSEL_DISABLED} cbsel_mode_t;
endpackage : cbsel_pkg

// ---- core/cbsel_regs.svh ----
// Constants for the buffer-manager transmit selection block
`ifndef CBSEL_REGS_SVH
`define CBSEL_REGS_SVH
// Module config bit positions
`define CBSEL_MCR_MULTI_BUFFER_MATCH_ENABLE_BIT   15
`define CBSEL_MCR_SELF_RECEIVE_DISABLE_BIT  14
// Buffer codes
`define CBSEL_CODE_INACTIVE   4'h0
`define CBSEL_CODE_RX_EMPTY   4'h4
`define CBSEL_CODE_RX_FULL    4'h2
`define CBSEL_CODE_TX_DATA    4'hC
`define CBSEL_CODE_TX_RANSWER 4'hA
// Intermission bit where an early start of frame is sampled
`define CBSEL_EARLY_SOF_BIT   2'h3
// Identifier bits taken from the previous candidate on early start
`define CBSEL_MIXED_ID_BITS   8
`endif

// ---- tb/cbsel_remote_node.sv ----
// Remote CAN node model driving bus events toward the selection block
`timescale 1ns/1ps
module cbsel_remote_node (
   input  wire logic        ref_clk,
   input  wire logic        clockStopReq,
   output logic             frameStart,
   output logic             frameEnd,
   output logic             intermissionBit3,
   output logic             dominantSample,
   output logic             rxRemote,
   output logic [10:0]      rxId,
   output logic             rxOwnFrame,
   output logic             clocksGated
);
   // ==========================================
   // Clock gate stands in for the external clock logic
   assign clocksGated = clockStopReq;
   initial begin
      frameStart       = 1'b0;
      frameEnd         = 1'b0;
      intermissionBit3 = 1'b0;
      dominantSample   = 1'b0;
      rxRemote         = 1'b0;
      rxId             = 11'h7FF;
      rxOwnFrame       = 1'b0;
   end
   // ==========================================
   // One whole frame; called just after a falling edge
   task automatic frame(input logic [10:0] id, input logic rmt, input logic own);
      frameStart = 1'b1;
      @(negedge ref_clk);
      frameStart = 1'b0;
      repeat (3) @(negedge ref_clk);
      frameEnd   = 1'b1;
      rxId       = id;
      rxRemote   = rmt;
      rxOwnFrame = own;
      @(negedge ref_clk);
      frameEnd   = 1'b0;
      rxId       = ~id; // Released id lines do not keep old value
      rxRemote   = 1'b0;
      rxOwnFrame = 1'b0;
   endtask : frame
   // Third intermission bit, dominant when early start is wanted
   task automatic bit3(input logic dom);
      intermissionBit3 = 1'b1;
      dominantSample   = dom;
      @(negedge ref_clk);
      intermissionBit3 = 1'b0;
      dominantSample   = ~dom;
   endtask : bit3
endmodule : cbsel_remote_node

// ---- tb/tb_cbsel_core.sv ----
// Self-checking bench for the transmit selection and mode handshake block
`timescale 1ns/1ps
module tb_cbsel_core;
   logic ref_clk = 1'b0, rst = 1'b1, module_disable_request = 1'b0, freezeReq = 1'b0;
   logic [15:0] moduleConfigReg = 16'h0000;
   logic [3:0]  lastIdx = 4'h3, csIdx = 4'h0, csCode = 4'h0, txIdx, rxIdx;
   logic        csWrite = 1'b0, txSent = 1'b0, txValid, busIdle, clockStopReq, low_power_ack, freeze_ack, rxStored;
   logic [10:0] csId = 11'h000, txId, rxId;
   logic [14:0] txCrc;
   logic        frameStart, frameEnd, intermissionBit3, dominantSample, rxRemote, rxOwnFrame, clocksGated;
   int          errors = 0, n_compared = 0;
   always #4 ref_clk = ~ref_clk;
   cbsel_core i_cbsel_core (.ref_clk(ref_clk), .rst(rst), .module_config_reg(moduleConfigReg),
      .last_buffer_index(lastIdx), .module_disable_request(module_disable_request), .freezeReq(freezeReq),
      .csWrite(csWrite), .csIdx(csIdx), .csCode(csCode), .csId(csId), .frameStart(frameStart),
      .frameEnd(frameEnd), .intermissionBit3(intermissionBit3), .dominantSample(dominantSample),
      .rxRemote(rxRemote), .rxId(rxId), .rxOwnFrame(rxOwnFrame), .txSent(txSent), .txValid(txValid),
      .txId(txId), .txIdx(txIdx), .txCrc(txCrc), .busIdle(busIdle), .clockStopReq(clockStopReq),
      .low_power_ack(low_power_ack), .freeze_ack(freeze_ack), .rxStored(rxStored), .rxIdx(rxIdx));
   cbsel_remote_node i_cbsel_remote_node (.ref_clk(ref_clk), .clockStopReq(clockStopReq),
      .frameStart(frameStart), .frameEnd(frameEnd), .intermissionBit3(intermissionBit3),
      .dominantSample(dominantSample), .rxRemote(rxRemote), .rxId(rxId), .rxOwnFrame(rxOwnFrame),
      .clocksGated(clocksGated));
   // ==========================================
   // Helpers: compare, buffer write, CRC reference
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic cs_write(input logic [3:0] idx, input logic [3:0] code, input logic [10:0] id);
      csWrite = 1'b1;
      csIdx   = idx;
      csCode  = code;
      csId    = id;
      @(negedge ref_clk);
      csWrite = 1'b0;
   endtask : cs_write
   function automatic logic [14:0] crc15(input logic [10:0] id);
      logic [14:0] c;
      logic        n;
      c = 15'h0000;
      for (int i = 10; i >= 0; i--) begin
         n = id[i] ^ c[14];
         c = {c[13:0], 1'b0};
         if (n) c = c ^ 15'h4599;
      end
      return c;
   endfunction : crc15
   task automatic tally_and_finish();
      if (errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk({15'h0000, txValid}, 16'h0000, "txValid after reset");
      chk({15'h0000, busIdle}, 16'h0001, "busIdle after reset");
      chk({13'h0000, clockStopReq, low_power_ack, freeze_ack}, 16'h0000, "mode flags after reset");
   endtask : t_reset
   task automatic t_select();
      cs_write(4'h1, 4'hC, 11'h123);
      cs_write(4'h2, 4'hC, 11'h055);
      cs_write(4'h5, 4'hC, 11'h001); // Beyond the last buffer, must be ignored
      i_cbsel_remote_node.frame(11'h7FF, 1'b0, 1'b0);
      @(negedge ref_clk);
      chk({15'h0000, txValid}, 16'h0001, "candidate valid");
      chk({5'h00, txId}, 16'h0055, "candidate id");
      chk({12'h000, txIdx}, 16'h0002, "candidate index");
      chk({1'b0, txCrc}, {1'b0, crc15(11'h055)}, "candidate crc");
   endtask : t_select
   task automatic t_cancel();
      cs_write(4'h3, 4'hA, 11'h200);
      i_cbsel_remote_node.frame(11'h111, 1'b1, 1'b0);
      @(negedge ref_clk);
      chk({15'h0000, txValid}, 16'h0000, "candidate cancelled");
      i_cbsel_remote_node.bit3(1'b0);
      cs_write(4'h3, 4'h0, 11'h000);
      @(negedge ref_clk);
      chk({15'h0000, txValid}, 16'h0001, "rewrite restores candidate");
      chk({15'h0000, busIdle}, 16'h0001, "idle after intermission");
   endtask : t_cancel
   task automatic t_early();
      i_cbsel_remote_node.frame(11'h7FF, 1'b0, 1'b0);
      @(negedge ref_clk);
      cs_write(4'h0, 4'hC, 11'h00A);
      i_cbsel_remote_node.bit3(1'b1);
      @(negedge ref_clk);
      chk({5'h00, txId}, {5'h00, 11'h055 & 11'h7F8 | 11'h002}, "mixed id");
      chk({1'b0, txCrc}, {1'b0, crc15(11'h052)}, "crc over mixed id");
      chk({12'h000, txIdx}, 16'h0000, "new buffer index");
      txSent = 1'b1;
      @(negedge ref_clk);
      txSent = 1'b0;
      chk({15'h0000, txValid}, 16'h0000, "candidate retired after send");
   endtask : t_early
   task automatic t_disable();
      freezeReq = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({15'h0000, freeze_ack}, 16'h0001, "freeze entered");
      module_disable_request = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({13'h0000, clockStopReq, low_power_ack, freeze_ack}, 16'h0006, "disable in freeze");
      chk({15'h0000, clocksGated}, 16'h0001, "clocks gated on request");
      module_disable_request = 1'b0;
      freezeReq = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({15'h0000, clockStopReq}, 16'h0000, "stop request withdrawn");
      chk({15'h0000, clocksGated}, 16'h0000, "clocks restored");
   endtask : t_disable
   task automatic t_rx();
      moduleConfigReg = 16'h8000;
      lastIdx = 4'h7;
      cs_write(4'h5, 4'h4, 11'h321);
      cs_write(4'h6, 4'h4, 11'h321);
      i_cbsel_remote_node.frame(11'h321, 1'b0, 1'b0);
      chk({11'h000, rxStored, rxIdx}, 16'h0015, "first queued frame");
      i_cbsel_remote_node.frame(11'h321, 1'b0, 1'b0);
      chk({11'h000, rxStored, rxIdx}, 16'h0016, "second queued frame");
      moduleConfigReg = 16'hC000;
      cs_write(4'h5, 4'h4, 11'h321);
      i_cbsel_remote_node.frame(11'h321, 1'b0, 1'b1);
      chk({15'h0000, rxStored}, 16'h0000, "own frame dropped");
      i_cbsel_remote_node.frame(11'h321, 1'b0, 1'b0);
      chk({15'h0000, rxStored}, 16'h0001, "foreign frame kept");
   endtask : t_rx
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      t_reset();
      t_select();
      t_cancel();
      t_early();
      t_disable();
      t_rx();
      tally_and_finish();
   end
endmodule : tb_cbsel_core
